// file: bench/mrts_link_asserts.sv
// checker: command link protocol and mode register contents seen on the link
`timescale 1ns/1ps
module mrts_link_asserts
  import mrts_pkg::*;
(
  input wire logic       hclk,    // device clock
  input wire logic       hresetn, // power-on reset, active low
  input wire logic       req,     // command strobe
  input wire logic       write,   // write when high
  input wire logic [5:0] addr,    // mode register address
  input wire logic [7:0] wdata,   // write operand
  input wire logic       rvalid,  // read strobe
  input wire logic [7:0] rdata    // read operand
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic       wsel;    // write set point as last written
  logic [7:0] cfg [2]; // shadow of both io configuration copies
  logic [6:3] stat;    // shadow of the writable status bits
  logic       prot;    // shadow of sticky repair protection

  // shadows follow the writes on the link; a refused write leaves all of them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wsel <= 1'b0;
      cfg  <= '{IO_CONFIG_RESET, IO_CONFIG_RESET};
      stat <= STATUS_RESET[6:3];
      prot <= 1'b0;
    end
    else if (req && write)
    begin
      if (addr == SETPOINT_ADDR)
        wsel <= wdata[WR_SETPOINT_BIT];
      if (addr == IO_CONFIG_ADDR)
        cfg[wsel] <= wdata;
      if (addr == IO_CONFIG_ADDR && wdata[REPAIR_PROT_BIT])
        prot <= 1'b1; // sticky: only reset clears it
      // protected entry attempt keeps the old entry bit, a reserved offset code keeps the old offset, the rest lands
      if (addr == STATUS_ADDR)
        stat <= {(wdata[6:5] == OFFSET_RESERVED) ? stat[6:5] : wdata[6:5],
                 (wdata[4] && prot) ? stat[4] : wdata[4], wdata[3]};
    end
  end

  // a read command and its answer one cycle later
  sequence s_rd(logic [5:0] a);
    req && !write && addr == a ##1 rvalid;
  endsequence

  property p_rd_answer; req && !write |=> rvalid; endproperty
  property p_rv_cause; rvalid |-> $past(req && !write); endproperty
  property p_rd_hold; $changed(rdata) |-> rvalid; endproperty
  property p_req_pulse; req |=> !req; endproperty
  property p_wr_quiet; req && write |=> !rvalid; endproperty
  property p_status_fields;
    s_rd(STATUS_ADDR) |-> rdata[3] == stat[3] && rdata[6:5] == stat[6:5];
  endproperty
  property p_repair; s_rd(STATUS_ADDR) |-> rdata[4] == stat[4]; endproperty
  // bits 1 and 2 are left out: postamble and protection have side rules
  property p_cfg_copy;
    s_rd(IO_CONFIG_ADDR) |-> (rdata & 8'hF9) == (cfg[wsel] & 8'hF9);
  endproperty

  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_rv_cause: assert property (p_rv_cause) else $error("read strobe without read");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_req_pulse: assert property (p_req_pulse) else $error("strobe longer than one cycle");
  a_wr_quiet: assert property (p_wr_quiet) else $error("write answered");
  a_status_fields: assert property (p_status_fields) else $error("status fields");
  a_repair: assert property (p_repair) else $error("repair entry bit");
  a_cfg_copy: assert property (p_cfg_copy) else $error("wrong set point copy");
endmodule : mrts_link_asserts

// file: bench/tb.sv
// testbench: AHB-Lite host driving controller and device across the link
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin compares++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module tb
  import mrts_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;  // bus control
  logic [31:0] haddr, hwdata, hrdata;                                  // bus data
  logic [1:0]  htrans;                                                 // transfer type
  logic [2:0]  hsize, sensor_rate;                                     // size, sensor code
  logic        init_done, sensor_hot, sensor_derate, fast_clock;       // device pins
  logic        pullup_cal_point, write_postamble_len, repair_protect;  // device levels
  logic        repair_mode, selfrefresh_abort_enable, operating_setpoint;
  logic [1:0]  thermal_offset;                                         // applied offset
  int          n_errors, compares;                                     // verdict counters

  mrts_link_if mrts_link_if_inst ();
  mrts_ctrl mrts_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .irq(irq), .link(mrts_link_if_inst.ctrl));
  mrts_device mrts_device_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .link(mrts_link_if_inst.dev), .init_done(init_done), .sensor_rate(sensor_rate),
    .sensor_hot(sensor_hot), .sensor_derate(sensor_derate), .fast_clock(fast_clock),
    .pullup_cal_point(pullup_cal_point), .write_postamble_len(write_postamble_len),
    .repair_protect(repair_protect), .repair_mode(repair_mode),
    .selfrefresh_abort_enable(selfrefresh_abort_enable),
    .thermal_offset(thermal_offset), .operating_setpoint(operating_setpoint));
  mrts_link_asserts mrts_link_asserts_inst (.hclk(hclk), .hresetn(hresetn),
    .req(mrts_link_if_inst.req), .write(mrts_link_if_inst.write),
    .addr(mrts_link_if_inst.addr), .wdata(mrts_link_if_inst.wdata),
    .rvalid(mrts_link_if_inst.rvalid), .rdata(mrts_link_if_inst.rdata));

  // 200 MHz clock
  always #2.5 hclk = ~hclk;

  // single place where the run ends
  task automatic report_and_stop;
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // a wait that ran out is a mismatch and ends the run
  task automatic limit(input int n);
    if (n > 20)
    begin
      n_errors++;
      $display("[FAIL] %0t wait timed out", $time);
      report_and_stop();
    end
  endtask : limit

  // reset held ten cycles; also serves as a power-on in mid-run
  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset

  // waits for the edge at which hready is sampled high
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      limit(n);
      @(posedge hclk);
    end
  endtask : wait_ready

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata; // taken at the data phase's ready edge
  endtask : bus

  // mode register command through the host, polled until no longer busy
  task automatic mr(input logic w, input logic [5:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    logic [31:0] r;
    int          n;
    bus(1'b1, HOST_CMD_OFS, {16'h0, 1'b1, w, a, d}, r);
    n = 0;
    r = 32'h100;
    while (r[8] !== 1'b0)
    begin
      bus(1'b0, HOST_RDATA_OFS, 32'h0, r);
      n++;
      limit(n);
    end
    // one more edge so levels launched by the command are settled when judged
    @(posedge hclk);
    q = r[7:0];
  endtask : mr

  // power-up values, unmapped host place, rate before init
  task automatic t_power_up;
    logic [31:0] r;
    logic [7:0]  q;
    `CHK({irq, hresp, repair_protect, repair_mode}, 4'h0);
    bus(1'b0, 8'h40, 32'h0, r);
    `CHK(r, 32'h0);
    sensor_rate <= 3'h5; // ignored until init completes
    mr(1'b0, STATUS_ADDR, 8'h00, q);
    `CHK(q[2:0], RATE_1X);
    `CHK(q[7], 1'b0);
  endtask : t_power_up

  // writes/reads go to the write copy, outputs follow the operating copy
  task automatic t_setpoints;
    logic [7:0] q;
    mr(1'b1, SETPOINT_ADDR, 8'h00, q);
    mr(1'b1, IO_CONFIG_ADDR, 8'h01, q);
    `CHK(pullup_cal_point, 1'b1);
    mr(1'b1, SETPOINT_ADDR, 8'h40, q);
    mr(1'b1, IO_CONFIG_ADDR, 8'h00, q);
    mr(1'b0, IO_CONFIG_ADDR, 8'h00, q);
    `CHK(q[0], 1'b0);
    `CHK(pullup_cal_point, 1'b1);
    mr(1'b1, SETPOINT_ADDR, 8'h80, q);
    `CHK({pullup_cal_point, operating_setpoint}, 2'h1);
    mr(1'b0, IO_CONFIG_ADDR, 8'h00, q);
    `CHK(q[0], 1'b1);
    mr(1'b1, SETPOINT_ADDR, 8'h00, q);
  endtask : t_setpoints

  // every offset code; rate bits written as ones must be dropped
  task automatic t_status_fields;
    logic [7:0] q;
    logic [1:0] off;
    off = 2'h0;
    for (int k = 0; k < 4; k++)
    begin
      mr(1'b1, STATUS_ADDR, {1'b1, k[1:0], 2'b01, 3'h7}, q);
      if (k != 3)
        off = k[1:0];
      mr(1'b0, STATUS_ADDR, 8'h00, q);
      `CHK(q[6:3], {off, 2'b01});
      `CHK(q[2:0], RATE_1X);
      `CHK(thermal_offset, off);
      `CHK(selfrefresh_abort_enable, 1'b1);
    end
  endtask : t_status_fields

  // repair entry and exit, protection, stickiness until power-on
  task automatic t_repair;
    logic [7:0] q;
    mr(1'b1, STATUS_ADDR, 8'h58, q);
    `CHK(repair_mode, 1'b1);
    mr(1'b1, STATUS_ADDR, 8'h48, q);
    `CHK(repair_mode, 1'b0);
    mr(1'b1, IO_CONFIG_ADDR, 8'h05, q);
    mr(1'b1, IO_CONFIG_ADDR, 8'h01, q);
    `CHK(repair_protect, 1'b1);
    mr(1'b1, STATUS_ADDR, 8'h58, q);
    mr(1'b0, STATUS_ADDR, 8'h00, q);
    `CHK({repair_mode, q[4]}, 2'h0);
    do_reset();
    `CHK(repair_protect, 1'b0);
  endtask : t_repair

  // every rate code, update flag set and cleared, limit events
  task automatic t_rate;
    logic [31:0] r;
    logic [7:0]  q;
    sensor_rate <= RATE_1X;
    init_done   <= 1'b1;
    mr(1'b0, STATUS_ADDR, 8'h00, q);
    `CHK(q[2:0], RATE_1X);
    bus(1'b1, HOST_STATUS_OFS, 32'hF, r);
    for (int c = 0; c < 8; c++)
    begin
      sensor_rate <= c[2:0];
      mr(1'b1, SETPOINT_ADDR, 8'h00, q); // spacer lets the synchroniser settle
      mr(1'b0, STATUS_ADDR, 8'h00, q);
      `CHK(q[2:0], c[2:0]);
      `CHK(q[7], 1'b1);
      mr(1'b0, STATUS_ADDR, 8'h00, q);
      `CHK(q[7], 1'b0);
      bus(1'b0, HOST_STATUS_OFS, 32'h0, r);
      `CHK(r[EV_LIMIT:EV_TEMP], {c == 0 || c == 7, 1'b1});
      bus(1'b1, HOST_STATUS_OFS, 32'hF, r);
    end
    sensor_rate <= 3'h1;
    sensor_hot  <= 1'b1;
    mr(1'b1, SETPOINT_ADDR, 8'h00, q);
    mr(1'b0, STATUS_ADDR, 8'h00, q);
    `CHK(q[2], 1'b1);
    sensor_derate <= 1'b1;
    mr(1'b1, SETPOINT_ADDR, 8'h00, q);
    mr(1'b0, STATUS_ADDR, 8'h00, q);
    `CHK(q[2:0], RATE_DERATE);
  endtask : t_rate

  // long postamble refused at a slow clock; interrupt masked, raised, cleared
  task automatic t_irq_post;
    logic [31:0] r;
    logic [7:0]  q;
    bus(1'b1, HOST_MASK_OFS, 32'h0, r);
    bus(1'b1, HOST_CLOCK_OFS, 32'h00000640, r);
    bus(1'b1, HOST_STATUS_OFS, 32'hF, r);
    mr(1'b1, IO_CONFIG_ADDR, 8'h02, q);
    `CHK(write_postamble_len, 1'b0);
    bus(1'b0, HOST_STATUS_OFS, 32'h0, r);
    `CHK({r[EV_REFUSED], irq}, 2'h2);
    bus(1'b1, HOST_MASK_OFS, 32'h8, r);
    bus(1'b0, HOST_MASK_OFS, 32'h0, r);
    `CHK({r[3:0], irq}, 5'h11);
    bus(1'b1, HOST_STATUS_OFS, 32'h8, r);
    bus(1'b0, HOST_STATUS_OFS, 32'h0, r);
    `CHK({r[EV_REFUSED], irq}, 2'h0);
    bus(1'b1, HOST_CLOCK_OFS, 32'h00000641, r);
    fast_clock <= 1'b1;
    mr(1'b1, IO_CONFIG_ADDR, 8'h02, q);
    `CHK(write_postamble_len, 1'b1);
  endtask : t_irq_post

  // main sequence
  initial
  begin
    {hclk, hresetn, hsel, hwrite, init_done, sensor_hot, sensor_derate, fast_clock} = '0;
    {haddr, hwdata, htrans, sensor_rate} = '0;
    hsize    = 3'h2;
    n_errors = 0;
    compares = 0;
    do_reset();
    t_power_up();
    t_setpoints();
    t_status_fields();
    t_repair();
    t_rate();
    t_irq_post();
    report_and_stop();
  end
endmodule : tb

// file: rtl/mrts_ctrl.sv
// controller end: AHB-Lite registers that issue mode register commands
`timescale 1ns/1ps
module mrts_ctrl
  import mrts_pkg::*;
(
  input  wire logic        hclk,      // bus clock
  input  wire logic        hresetn,   // async reset, active low
  input  wire logic        clk_en,    // freezes state when low
  input  wire logic        hsel,      // slave select
  input  wire logic [31:0] haddr,     // address
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write
  input  wire logic [2:0]  hsize,     // size, word only
  input  wire logic [31:0] hwdata,    // write data
  input  wire logic        hready,    // bus ready
  output logic [31:0]      hrdata,    // read data
  output logic             hreadyout, // always ready
  output logic             hresp,     // always OKAY
  output logic             irq,       // level interrupt
  mrts_link_if.ctrl        link       // command link
);
  logic [7:0]      a_addr;     // latched address phase
  logic            a_wr;       // latched write
  logic            a_rd;       // latched read
  logic [7:0]      rd_data;    // last read data
  logic            busy;       // read outstanding
  logic [EV_W-1:0] events;     // sticky events
  logic [EV_W-1:0] mask;       // interrupt mask
  logic [15:0]     clock_mhz;  // link clock rate
  logic [EV_W-1:0] ev_set;     // event pulses
  logic            go;         // command request accepted

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_addr <= 8'h00;
      a_wr   <= 1'b0;
      a_rd   <= 1'b0;
    end
    else if (clk_en && hready)
    begin
      a_addr <= haddr[7:0];
      a_wr   <= hsel && htrans[1] && hwrite;
      a_rd   <= hsel && htrans[1] && !hwrite;
    end
  end

  assign go = clk_en && a_wr && a_addr == HOST_CMD_OFS && hwdata[15] && !busy;

  // postamble requests at or below 1.6GHz are refused before reaching the device
  always_comb
  begin
    ev_set = '0;
    ev_set[EV_DONE]    = link.rvalid || (go && hwdata[14]);
    ev_set[EV_TEMP]    = link.rvalid && link.rdata[UPDATE_FLAG_BIT] && a_addr != 8'hFF;
    ev_set[EV_LIMIT]   = link.rvalid && (link.rdata[2:0] == RATE_LOW_LIMIT
                         || link.rdata[2:0] == RATE_HIGH_LIMIT);
    ev_set[EV_REFUSED] = go && hwdata[14] && hwdata[13:8] == IO_CONFIG_ADDR
                         && hwdata[POSTAMBLE_BIT] && clock_mhz <= POSTAMBLE_MIN_MHZ;
  end

  // command issue, one-cycle strobe
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      link.req   <= 1'b0;
      link.write <= 1'b0;
      link.addr  <= 6'h00;
      link.wdata <= 8'h00;
    end
    else if (clk_en)
    begin
      link.req <= go && !ev_set[EV_REFUSED];
      if (go)
      begin
        link.write <= hwdata[14];
        link.addr  <= hwdata[13:8];
        link.wdata <= hwdata[7:0];
      end
    end
  end

  // registers: busy, read data, events, mask, clock rate
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy      <= 1'b0;
      rd_data   <= 8'h00;
      events    <= '0;
      mask      <= '0;
      clock_mhz <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (go && !hwdata[14] && !ev_set[EV_REFUSED])
        busy <= 1'b1;
      else if (link.rvalid)
        busy <= 1'b0;
      if (link.rvalid)
        rd_data <= link.rdata;
      // set wins over write-one-to-clear
      if (a_wr && a_addr == HOST_STATUS_OFS)
        events <= (events & ~hwdata[EV_W-1:0]) | ev_set;
      else
        events <= events | ev_set;
      if (a_wr && a_addr == HOST_MASK_OFS)
        mask <= hwdata[EV_W-1:0];
      if (a_wr && a_addr == HOST_CLOCK_OFS)
        clock_mhz <= hwdata[15:0];
    end
  end

  // read data, interrupt, fixed OKAY response
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irq       <= 1'b0;
    end
    else if (clk_en)
    begin
      irq <= |((events | ev_set) & mask);
      if (hready && hsel && htrans[1] && !hwrite)
      begin
        case (haddr[7:0])
          HOST_RDATA_OFS:  hrdata <= {23'h000000, busy, rd_data};
          HOST_STATUS_OFS: hrdata <= {28'h0000000, events};
          HOST_MASK_OFS:   hrdata <= {28'h0000000, mask};
          HOST_CLOCK_OFS:  hrdata <= {16'h0000, clock_mhz};
          default:         hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule : mrts_ctrl

// file: rtl/mrts_device.sv
// device end: io configuration set points and refresh/temperature status register
`timescale 1ns/1ps
module mrts_device
  import mrts_pkg::*;
(
  input  wire logic       hclk,              // device clock
  input  wire logic       hresetn,           // power-on reset, active low
  input  wire logic       clk_en,            // freezes all state when low
  mrts_link_if.dev        link,              // mode register commands
  input  wire logic       init_done,         // initialization sequence complete (pin)
  input  wire logic [2:0] sensor_rate,       // sensor refresh code (pin)
  input  wire logic       sensor_hot,        // above 85 degrees (pin)
  input  wire logic       sensor_derate,     // timing derating needed (pin)
  input  wire logic       fast_clock,        // link clock above 1.6GHz (pin)
  output logic            pullup_cal_point,  // active pull-up calibration point
  output logic            write_postamble_len, // active long postamble
  output logic            repair_protect,    // repair protection enabled
  output logic            repair_mode,       // in post-package repair
  output logic            selfrefresh_abort_enable, // self refresh abort
  output logic [1:0]      thermal_offset,    // applied thermal offset
  output logic            operating_setpoint // active set point
);
  logic [7:0] io_cfg [2];       // two physical copies of io_config_reg
  logic [7:0] setpoint;         // set-point control register
  logic [7:0] status_wr;        // writable status bits 6..3
  logic [2:0] rate;             // reported refresh-rate code
  logic       update_flag;      // temp_update_flag
  logic [5:0] sync1;            // first stage of pin synchronisers
  logic [5:0] sync2;            // second stage
  logic [2:0] sync_rate1;       // first stage rate
  logic [2:0] sync_rate2;       // second stage rate
  logic       wr_sel;           // write set point
  logic       op_sel;           // operating set point
  logic       wr_io;            // write to io_config_reg
  logic       wr_st;            // write to status register
  logic       rd_st;            // read of status register
  logic [2:0] next_rate;        // rate code to report
  logic [7:0] status_word;      // assembled status value
  logic [7:0] next_status_wr;   // status write after masking

  assign wr_sel = setpoint[WR_SETPOINT_BIT];
  assign op_sel = setpoint[OP_SETPOINT_BIT];
  assign wr_io  = link.req && link.write && link.addr == IO_CONFIG_ADDR;
  assign wr_st  = link.req && link.write && link.addr == STATUS_ADDR;
  assign rd_st  = link.req && !link.write && link.addr == STATUS_ADDR;

  // pins cross in from the sensor domain through two flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1      <= 6'h00;
      sync2      <= 6'h00;
      sync_rate1 <= 3'h0;
      sync_rate2 <= 3'h0;
    end
    else if (clk_en)
    begin
      sync1      <= {2'h0, init_done, sensor_hot, sensor_derate, fast_clock};
      sync2      <= sync1;
      sync_rate1 <= sensor_rate;
      sync_rate2 <= sync_rate1;
    end
  end

  // rate code: derating forces 110, hot forces msb, default 1x until init
  always_comb
  begin
    if (!sync2[3])
      next_rate = RATE_1X;
    else if (sync2[1])
      next_rate = RATE_DERATE;
    else if (sync2[2])
      next_rate = {1'b1, sync_rate2[1:0]};
    else
      next_rate = sync_rate2;
  end

  // reported rate
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rate <= RATE_1X;
    else if (clk_en)
      rate <= next_rate;
  end

  // update flag: change sets, status read clears, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      update_flag <= 1'b0;
    else if (clk_en)
    begin
      if (next_rate != rate)
        update_flag <= 1'b1;
      else if (rd_st)
        update_flag <= 1'b0;
    end
  end

  // set-point control register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      setpoint <= 8'h00;
    else if (clk_en && link.req && link.write && link.addr == SETPOINT_ADDR)
      setpoint <= link.wdata;
  end

  // io_config_reg copies; protection bit only ever rises
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      io_cfg[0] <= IO_CONFIG_RESET;
      io_cfg[1] <= IO_CONFIG_RESET;
    end
    else if (clk_en && wr_io)
    begin
      io_cfg[wr_sel] <= link.wdata;
      io_cfg[wr_sel][REPAIR_PROT_BIT] <= link.wdata[REPAIR_PROT_BIT]
                                         | repair_protect;
    end
  end

  // sticky repair protection, cleared only by power-on reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      repair_protect <= 1'b0;
    else if (clk_en && wr_io && link.wdata[REPAIR_PROT_BIT])
      repair_protect <= 1'b1;
  end

  // status writes keep bits 6..3; protected entry is refused
  always_comb
  begin
    next_status_wr = (link.wdata & STATUS_WR_MASK) | (status_wr & ~STATUS_WR_MASK);
    if (repair_protect && link.wdata[REPAIR_ENTRY_BIT])
      next_status_wr[REPAIR_ENTRY_BIT] = status_wr[REPAIR_ENTRY_BIT];
    if (link.wdata[OFFSET_MSB:OFFSET_LSB] == OFFSET_RESERVED)
      next_status_wr[OFFSET_MSB:OFFSET_LSB] = status_wr[OFFSET_MSB:OFFSET_LSB];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_wr <= STATUS_RESET;
    else if (clk_en && wr_st)
      status_wr <= next_status_wr;
  end

  assign status_word = {update_flag, status_wr[OFFSET_MSB:SELFREFRESH_ABORT_ENABLE_BIT], rate};

  // read answer one cycle after the command; reads use the write set point
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      link.rvalid <= 1'b0;
      link.rdata  <= 8'h00;
    end
    else if (clk_en)
    begin
      link.rvalid <= link.req && !link.write;
      if (link.req && !link.write)
      begin
        case (link.addr)
          IO_CONFIG_ADDR: link.rdata <= io_cfg[wr_sel];
          STATUS_ADDR:    link.rdata <= status_word;
          SETPOINT_ADDR:  link.rdata <= setpoint;
          default:        link.rdata <= 8'h00;
        endcase
      end
    end
  end

  // io configuration outputs follow only the operating set point
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pullup_cal_point         <= 1'b0;
      write_postamble_len      <= 1'b0;
      repair_mode              <= 1'b0;
      selfrefresh_abort_enable <= 1'b0;
      thermal_offset           <= 2'h0;
      operating_setpoint       <= 1'b0;
    end
    else if (clk_en)
    begin
      pullup_cal_point         <= io_cfg[op_sel][PULLUP_CAL_BIT];
      // long postamble only honoured on a fast link clock
      write_postamble_len      <= io_cfg[op_sel][POSTAMBLE_BIT] & sync2[0];
      repair_mode              <= status_wr[REPAIR_ENTRY_BIT];
      selfrefresh_abort_enable <= status_wr[SELFREFRESH_ABORT_ENABLE_BIT];
      thermal_offset           <= status_wr[OFFSET_MSB:OFFSET_LSB];
      operating_setpoint       <= op_sel;
    end
  end
endmodule : mrts_device

// file: rtl/mrts_link_if.sv
// interface: mode register command link between controller and device
`timescale 1ns/1ps
interface mrts_link_if;
  logic       req;      // command strobe, one cycle
  logic       write;    // 1 write, 0 read
  logic [5:0] addr;     // mode register address
  logic [7:0] wdata;    // write operand
  logic       rvalid;   // read data strobe
  logic [7:0] rdata;    // read operand
  modport ctrl (output req, write, addr, wdata, input rvalid, rdata);
  modport dev  (input req, write, addr, wdata, output rvalid, rdata);
endinterface : mrts_link_if

// file: rtl/mrts_pkg.sv
// package: constants shared by the mode-register status device and its controller
package mrts_pkg;
  localparam logic [5:0] IO_CONFIG_ADDR      = 6'h03; // io_config_reg address
  localparam logic [5:0] STATUS_ADDR         = 6'h04; // refresh_temp_status address
  localparam logic [5:0] SETPOINT_ADDR       = 6'h0D; // set-point control register address
  localparam int         PULLUP_CAL_BIT      = 0;     // io_config_reg pullup_cal_point
  localparam int         POSTAMBLE_BIT       = 1;     // io_config_reg write_postamble_len
  localparam int         REPAIR_PROT_BIT     = 2;     // io_config_reg repair protection
  localparam int         WR_SETPOINT_BIT     = 6;     // write_setpoint_select
  localparam int         OP_SETPOINT_BIT     = 7;     // operating_setpoint_select
  localparam int         RATE_LSB            = 0;     // refresh-rate field low bit
  localparam int         RATE_MSB            = 2;     // refresh-rate field high bit
  localparam int         SELFREFRESH_ABORT_ENABLE_BIT        = 3;     // selfrefresh_abort_enable
  localparam int         REPAIR_ENTRY_BIT    = 4;     // repair_entry_bit
  localparam int         OFFSET_LSB          = 5;     // thermal offset low bit
  localparam int         OFFSET_MSB          = 6;     // thermal offset high bit
  localparam int         UPDATE_FLAG_BIT     = 7;     // temp_update_flag
  localparam logic [7:0] STATUS_WR_MASK      = 8'h78; // writable bits 6..3
  localparam logic [2:0] RATE_LOW_LIMIT      = 3'h0;  // below operating limit
  localparam logic [2:0] RATE_1X             = 3'h3;  // 85 degrees, default
  localparam logic [2:0] RATE_DERATE         = 3'h6;  // quarter rate with derating
  localparam logic [2:0] RATE_HIGH_LIMIT     = 3'h7;  // above operating limit
  localparam logic [1:0] OFFSET_RESERVED     = 2'h3;  // thermal offset code 11
  localparam logic [7:0] IO_CONFIG_RESET     = 8'h00; // per set point reset
  localparam logic [7:0] STATUS_RESET        = 8'h00; // writable status bits reset
  localparam int         POSTAMBLE_MIN_MHZ   = 1600;  // long postamble needs faster clock
  // host registers over AHB-Lite
  localparam logic [7:0] HOST_CMD_OFS        = 8'h00; // [15]go [14]write [13:8]addr [7:0]data
  localparam logic [7:0] HOST_RDATA_OFS      = 8'h04; // last read data, [8] busy
  localparam logic [7:0] HOST_STATUS_OFS     = 8'h08; // sticky events, write one clears
  localparam logic [7:0] HOST_MASK_OFS       = 8'h0C; // interrupt mask
  localparam logic [7:0] HOST_CLOCK_OFS      = 8'h10; // link clock rate in MHz
  localparam int         EV_DONE             = 0;     // command finished
  localparam int         EV_TEMP             = 1;     // bit 7 (update flag) seen set on a read answer while the latched host address is not FF
  localparam int         EV_LIMIT            = 2;     // out-of-range rate code seen
  localparam int         EV_REFUSED          = 3;     // postamble refused at low clock
  localparam int         EV_W                = 4;     // event count
endpackage : mrts_pkg
